// >>> rtl/vgd_pkg.sv
package vgd_pkg;

    // Host I/O ports of the index/data pair
    localparam logic [15:0] IDX_PORT = 16'h03CE;
    localparam logic [15:0] DATA_PORT = 16'h03CF;

    // Register indices
    localparam logic [3:0] IDX_ROTATE = 4'h3;
    localparam logic [3:0] IDX_READ_MAP = 4'h4;
    localparam logic [3:0] IDX_MODE = 4'h5;
    localparam logic [3:0] IDX_MISC = 4'h6;

    // Writable bits; reserved bits read as zero
    localparam logic [7:0] INDEX_MASK = 8'h0F;
    localparam logic [7:0] ROT_MASK = 8'h1F;
    localparam logic [7:0] RMS_MASK = 8'h03;
    localparam logic [7:0] MODE_MASK = 8'h7B;
    localparam logic [7:0] MISC_MASK = 8'h0F;
    localparam logic [7:0] REG_RESET = 8'h00;

    // Field positions
    localparam int ROT_CNT_LSB = 0;
    localparam int FUNC_LSB = 3;
    localparam int RMS_LSB = 0;
    localparam int WMODE_LSB = 0;
    localparam int RDMODE_BIT = 3;
    localparam int OE_GFX_BIT = 4;
    localparam int SHIFT_FMT_BIT = 5;
    localparam int C256_BIT = 6;
    localparam int MISC_GFX_BIT = 0;
    localparam int MISC_OE_BIT = 1;
    localparam int MISC_MAP_LSB = 2;

    // Offset bit that replaces the low memory address bit in odd/even
    localparam int ODD_HI_BIT = 16;

    // CPU display windows
    localparam logic [19:0] WIN_A_BASE = 20'hA_0000;
    localparam logic [19:0] WIN_B_BASE = 20'hB_0000;
    localparam logic [19:0] WIN_B8_BASE = 20'hB_8000;
    localparam logic [19:0] SIZE_128K = 20'h2_0000;
    localparam logic [19:0] SIZE_64K = 20'h1_0000;
    localparam logic [19:0] SIZE_32K = 20'h0_8000;

    typedef enum logic [1:0] {FN_PASS, FN_AND, FN_OR, FN_XOR} vgd_func_t;
    typedef enum logic [1:0] {WM_0, WM_1, WM_2, WM_3} vgd_wmode_t;
    typedef enum logic [1:0] {WIN_128K, WIN_64K, WIN_32K_LO, WIN_32K_HI}
        vgd_win_t;

    // CPU memory request, one cycle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [19:0] addr;
        logic [7:0] data;
    } vgd_cpu_req_t;

    // Command to the four display maps, one cycle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] map_en;
        logic [15:0] addr;
        logic [31:0] data;
    } vgd_mem_cmd_t;

    // Registers held by neighbouring controllers
    typedef struct packed {
        logic [3:0] set_reset;
        logic [3:0] sr_enable;
        logic [3:0] color_cmp;
        logic [3:0] color_dc;
        logic [7:0] bit_mask;
        logic [3:0] map_mask;
        logic seq_chain4;
    } vgd_ext_regs_t;

endpackage

// >>> rtl/vgd_shifter.sv
module vgd_shifter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic dot_en,
    input wire logic [31:0] load_data,
    input wire logic mode256,
    input wire logic shift_fmt,
    output logic [7:0] pix
);

    typedef struct packed {
        logic [3:0][7:0] sr;
        logic [7:0] pix;
    } vgd_sh_state_t;

    vgd_sh_state_t st_r;
    vgd_sh_state_t st_nxt;

    // Even or odd bits of two map bytes, high map first
    function automatic logic [7:0] pick(input logic [7:0] hi,
                                        input logic [7:0] lo,
                                        input logic odd);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 4; i++) begin
            r[4 + i] = hi[2 * i + int'(odd)];
            r[i] = lo[2 * i + int'(odd)];
        end
        return r;
    endfunction

    // Load beats shift; MSB leaves first in every format
    always_comb begin
        st_nxt = st_r;
        if (load) begin
            for (int k = 0; k < 4; k++) begin
                st_nxt.sr[k] = load_data[8 * k +: 8];
            end
            if (shift_fmt && !mode256) begin
                st_nxt.sr[0] = pick(load_data[7:0], load_data[15:8], 1'b0);
                st_nxt.sr[1] = pick(load_data[7:0], load_data[15:8], 1'b1);
                st_nxt.sr[2] = pick(load_data[23:16], load_data[31:24],
                                    1'b0);
                st_nxt.sr[3] = pick(load_data[23:16], load_data[31:24],
                                    1'b1);
            end
        end else if (dot_en) begin
            if (mode256) begin
                for (int k = 0; k < 4; k++) begin
                    st_nxt.pix[2 * k +: 2] = st_r.sr[k][7:6];
                    st_nxt.sr[k] = {st_r.sr[k][5:0], 2'b00};
                end
            end else begin
                st_nxt.pix = 8'h00;
                for (int k = 0; k < 4; k++) begin
                    st_nxt.pix[k] = st_r.sr[k][7];
                    st_nxt.sr[k] = {st_r.sr[k][6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pix = st_r.pix;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_shift_msb_first: assert property (
        dot_en && !load && !mode256 |=> pix[3:0] ==
            {$past(st_r.sr[3][7]), $past(st_r.sr[2][7]),
             $past(st_r.sr[1][7]), $past(st_r.sr[0][7])})
        else $error("shift register did not emit its MSB");

endmodule

// >>> rtl/vgd_datapath.sv
module vgd_datapath (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input vgd_pkg::vgd_ext_regs_t ext,
    input vgd_pkg::vgd_cpu_req_t cpu_req,
    output logic cpu_hit,
    output logic [7:0] cpu_rdata,
    output logic cpu_rd_valid,
    output vgd_pkg::vgd_mem_cmd_t mem_cmd,
    input wire logic [31:0] mem_rdata,
    output logic memory_addr_bit_zero,
    input wire logic vid_load,
    input wire logic vid_dot_en,
    input wire logic [31:0] vid_load_data,
    input wire logic [95:0] palette_flat,
    input wire logic [3:0] attr_color_sel,
    output logic [5:0] pixel_out_low_six,
    output logic pixel_out_bit_six,
    output logic pixel_out_bit_seven,
    output logic gfx_mode_sel
);

    typedef struct packed {
        logic [3:0] index;
        logic [7:0] rotate;
        logic [7:0] read_map;
        logic [7:0] mode;
        logic [7:0] misc;
        logic [31:0] latch;
        logic [7:0] io_rdata;
        logic [7:0] cpu_rdata;
        logic rd_valid;
        logic [1:0] rd_map;
        logic rd_cmp;
        vgd_pkg::vgd_mem_cmd_t mem;
        logic [7:0] pix;
    } vgd_dp_state_t;

    vgd_dp_state_t st_r;
    vgd_dp_state_t st_nxt;
    logic [7:0] sh_pix;

    // Right rotate with wrap of the low bits
    function automatic logic [7:0] ror8(input logic [7:0] d,
                                        input logic [2:0] n);
        return 8'((({d, d}) >> n));
    endfunction

    // Byte of one map out of the 32-bit map word
    function automatic logic [7:0] map_byte(input logic [31:0] w,
                                            input logic [1:0] k);
        return w[8 * k +: 8];
    endfunction

    // Colour compare across the four maps
    function automatic logic [7:0] cmp_fn(input logic [31:0] w,
                                          input logic [3:0] cc,
                                          input logic [3:0] dc);
        logic [7:0] r;
        r = 8'hFF;
        for (int k = 0; k < 4; k++) begin
            if (dc[k]) begin
                r = r & ~(w[8 * k +: 8] ^ {8{cc[k]}});
            end
        end
        return r;
    endfunction

    // Window decode: {hit, offset}
    function automatic logic [17:0] win_fn(input logic [19:0] a,
                                           input logic [1:0] sel);
        logic [19:0] base;
        logic [19:0] size;
        logic [19:0] off;
        base = vgd_pkg::WIN_A_BASE;
        size = vgd_pkg::SIZE_128K;
        case (vgd_pkg::vgd_win_t'(sel))
            vgd_pkg::WIN_128K: begin
                size = vgd_pkg::SIZE_128K;
            end
            vgd_pkg::WIN_64K: begin
                size = vgd_pkg::SIZE_64K;
            end
            vgd_pkg::WIN_32K_LO: begin
                base = vgd_pkg::WIN_B_BASE;
                size = vgd_pkg::SIZE_32K;
            end
            default: begin
                base = vgd_pkg::WIN_B8_BASE;
                size = vgd_pkg::SIZE_32K;
            end
        endcase
        off = a - base;
        return {(a >= base) && (off < size), off[16:0]};
    endfunction

    // Decoded fields
    logic [2:0] rot_cnt;
    vgd_pkg::vgd_func_t func;
    vgd_pkg::vgd_wmode_t wmode;
    logic odd_even;
    logic [17:0] win;
    logic [16:0] off;
    logic [7:0] cpu_rot;
    logic io_idx_sel;
    logic io_dat_sel;

    assign rot_cnt = st_r.rotate[vgd_pkg::ROT_CNT_LSB +: 3];
    assign func = vgd_pkg::vgd_func_t'(st_r.rotate[vgd_pkg::FUNC_LSB +: 2]);
    assign wmode = vgd_pkg::vgd_wmode_t'(
        st_r.mode[vgd_pkg::WMODE_LSB +: 2]);
    assign odd_even = st_r.mode[vgd_pkg::OE_GFX_BIT] |
                      st_r.misc[vgd_pkg::MISC_OE_BIT];
    assign win = win_fn(cpu_req.addr, st_r.misc[vgd_pkg::MISC_MAP_LSB +: 2]);
    assign off = win[16:0];
    assign cpu_hit = win[17];
    assign cpu_rot = ror8(cpu_req.data, rot_cnt);
    assign io_idx_sel = io_addr == vgd_pkg::IDX_PORT;
    assign io_dat_sel = io_addr == vgd_pkg::DATA_PORT;

    // New map data for a CPU write, merged with the latches
    logic [31:0] wr_data;
    always_comb begin
        logic [7:0] src;
        logic [7:0] alu;
        logic [7:0] mask;
        logic [7:0] lat;
        wr_data = st_r.latch;
        src = 8'h00;
        alu = 8'h00;
        mask = 8'h00;
        lat = 8'h00;
        for (int k = 0; k < 4; k++) begin
            lat = st_r.latch[8 * k +: 8];
            mask = ext.bit_mask;
            case (wmode)
                vgd_pkg::WM_0: begin
                    src = ext.sr_enable[k] ? {8{ext.set_reset[k]}}
                                           : cpu_rot;
                end
                vgd_pkg::WM_2: begin
                    src = {8{cpu_req.data[k]}};
                end
                vgd_pkg::WM_3: begin
                    src = {8{ext.set_reset[k]}};
                    mask = cpu_rot & ext.bit_mask;
                end
                default: begin
                    src = lat;
                    mask = 8'hFF;
                end
            endcase
            alu = src;
            if (wmode == vgd_pkg::WM_0 || wmode == vgd_pkg::WM_2) begin
                case (func)
                    vgd_pkg::FN_AND: alu = src & lat;
                    vgd_pkg::FN_OR: alu = src | lat;
                    vgd_pkg::FN_XOR: alu = src ^ lat;
                    default: alu = src;
                endcase
            end
            wr_data[8 * k +: 8] = (alu & mask) | (lat & ~mask);
        end
    end

    // Map enables and memory address for the CPU access
    logic [3:0] acc_maps;
    logic [15:0] acc_addr;
    logic [1:0] acc_rd_map;
    always_comb begin
        acc_maps = ext.map_mask;
        acc_addr = off[15:0];
        acc_rd_map = st_r.read_map[vgd_pkg::RMS_LSB +: 2];
        if (ext.seq_chain4) begin
            acc_maps = ext.map_mask & (4'h1 << off[1:0]);
            acc_rd_map = off[1:0];
        end else if (odd_even) begin
            // Even offsets hit maps 0/2, odd ones maps 1/3
            acc_maps = ext.map_mask & (off[0] ? 4'hA : 4'h5);
            acc_addr = {off[15:1], off[vgd_pkg::ODD_HI_BIT]};
            acc_rd_map = {st_r.read_map[vgd_pkg::RMS_LSB + 1], off[0]};
        end
    end

    // Register read-back, reserved bits zero
    function automatic logic [7:0] reg_read(input vgd_dp_state_t s);
        logic [7:0] r;
        r = 8'h00;
        if (s.index == vgd_pkg::IDX_ROTATE) begin
            r = s.rotate;
        end else if (s.index == vgd_pkg::IDX_READ_MAP) begin
            r = s.read_map;
        end else if (s.index == vgd_pkg::IDX_MODE) begin
            r = s.mode;
        end else if (s.index == vgd_pkg::IDX_MISC) begin
            r = s.misc;
        end
        return r;
    endfunction

    // Next state: host port, CPU access, read return, pixel path
    always_comb begin
        st_nxt = st_r;
        st_nxt.rd_valid = 1'b0;
        st_nxt.mem.rd = 1'b0;
        st_nxt.mem.wr = 1'b0;
        // Index/data port pair; unlisted indices read zero
        if (io_wr && io_idx_sel) begin
            st_nxt.index = io_wdata[3:0] & vgd_pkg::INDEX_MASK[3:0];
        end else if (io_wr && io_dat_sel) begin
            if (st_r.index == vgd_pkg::IDX_ROTATE) begin
                st_nxt.rotate = io_wdata & vgd_pkg::ROT_MASK;
            end else if (st_r.index == vgd_pkg::IDX_READ_MAP) begin
                st_nxt.read_map = io_wdata & vgd_pkg::RMS_MASK;
            end else if (st_r.index == vgd_pkg::IDX_MODE) begin
                st_nxt.mode = io_wdata & vgd_pkg::MODE_MASK;
            end else if (st_r.index == vgd_pkg::IDX_MISC) begin
                st_nxt.misc = io_wdata & vgd_pkg::MISC_MASK;
            end
        end
        if (io_rd && io_idx_sel) begin
            st_nxt.io_rdata = {4'h0, st_r.index};
        end else if (io_rd && io_dat_sel) begin
            st_nxt.io_rdata = reg_read(st_r);
        end
        // A miss outside the window issues nothing
        if (cpu_hit && cpu_req.wr) begin
            st_nxt.mem.wr = 1'b1;
            st_nxt.mem.map_en = acc_maps;
            st_nxt.mem.addr = acc_addr;
            st_nxt.mem.data = wr_data;
        end else if (cpu_hit && cpu_req.rd) begin
            st_nxt.mem.rd = 1'b1;
            st_nxt.mem.map_en = acc_maps;
            st_nxt.mem.addr = acc_addr;
            st_nxt.rd_map = acc_rd_map;
            st_nxt.rd_cmp = st_r.mode[vgd_pkg::RDMODE_BIT];
        end
        // Maps answer during the command cycle
        if (st_r.mem.rd) begin
            st_nxt.latch = mem_rdata;
            st_nxt.rd_valid = 1'b1;
            st_nxt.cpu_rdata = st_r.rd_cmp ?
                cmp_fn(mem_rdata, ext.color_cmp, ext.color_dc) :
                map_byte(mem_rdata, st_r.rd_map);
        end
        // Palette applies only outside 256-colour mode
        if (st_r.mode[vgd_pkg::C256_BIT]) begin
            st_nxt.pix = sh_pix;
        end else begin
            st_nxt.pix = {attr_color_sel[3:2],
                          palette_flat[6 * sh_pix[3:0] +: 6]};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    vgd_shifter u_shifter (
        .clk(clk),
        .rst_n(rst_n),
        .load(vid_load),
        .dot_en(vid_dot_en),
        .load_data(vid_load_data),
        .mode256(st_r.mode[vgd_pkg::C256_BIT]),
        .shift_fmt(st_r.mode[vgd_pkg::SHIFT_FMT_BIT]),
        .pix(sh_pix)
    );

    // Outputs straight from flip-flops
    assign io_rdata = st_r.io_rdata;
    assign cpu_rdata = st_r.cpu_rdata;
    assign cpu_rd_valid = st_r.rd_valid;
    assign mem_cmd = st_r.mem;
    assign memory_addr_bit_zero = st_r.mem.addr[0];
    assign pixel_out_low_six = st_r.pix[5:0];
    assign pixel_out_bit_six = st_r.pix[6];
    assign pixel_out_bit_seven = st_r.pix[7];
    assign gfx_mode_sel = st_r.misc[vgd_pkg::MISC_GFX_BIT];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_rd_issue;
        cpu_req.rd && !cpu_req.wr && cpu_hit;
    endsequence

    sequence s_rd_done;
        cpu_rd_valid;
    endsequence

    a_read_two_cycles: assert property (
        s_rd_issue |=> mem_cmd.rd ##1 s_rd_done)
        else $error("read did not complete two cycles later");

    a_read_map_byte: assert property (
        mem_cmd.rd && !st_r.rd_cmp |=> cpu_rdata ==
            8'($past(mem_rdata) >> (8 * $past(st_r.rd_map))))
        else $error("read byte not from the selected map");

    a_cmp_read: assert property (
        mem_cmd.rd && st_r.rd_cmp |=> cpu_rdata == cmp_fn($past(mem_rdata),
            $past(ext.color_cmp), $past(ext.color_dc)))
        else $error("colour compare result wrong");

    a_chain_map: assert property (
        s_rd_issue ##0 ext.seq_chain4 |=> st_r.rd_map == $past(off[1:0]))
        else $error("chained read ignored the address");

    a_latch_load: assert property (
        mem_cmd.rd |=> st_r.latch == $past(mem_rdata))
        else $error("latches not reloaded by read");

    a_wm1_copy: assert property (
        cpu_req.wr && cpu_hit && wmode == vgd_pkg::WM_1
            |=> mem_cmd.wr && mem_cmd.data == $past(st_r.latch))
        else $error("write mode 1 did not copy latches");

    a_mask_keeps: assert property (
        cpu_req.wr && cpu_hit && wmode != vgd_pkg::WM_3
            |=> ((mem_cmd.data ^ $past(st_r.latch))
                 & ~{4{$past(ext.bit_mask)}}) == 32'h0000_0000)
        else $error("masked bit changed");

    a_odd_even_maps: assert property (
        cpu_req.wr && cpu_hit && odd_even && !ext.seq_chain4 && !off[0]
            |=> mem_cmd.map_en[1] == 1'b0 && mem_cmd.map_en[3] == 1'b0)
        else $error("even address reached an odd map");

    a_window_miss: assert property (
        (cpu_req.wr || cpu_req.rd) && !cpu_hit
            |=> !mem_cmd.wr && !mem_cmd.rd)
        else $error("access outside the window reached memory");

endmodule

// >>> testbench/vgd_mem_model.sv
// Four display maps on the far side of the datapath
module vgd_mem_model (
    input wire logic clk,
    input wire vgd_pkg::vgd_mem_cmd_t mem_cmd,
    output logic [31:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] m [0:3][0:65535];
    logic [31:0] word;

    // Maps start cleared so latch contents are known
    initial begin
        for (int k = 0; k < 4; k++) begin
            for (int a = 0; a < 65536; a++) begin
                m[k][a] = 8'h00;
            end
        end
    end

    // Inverted data outside reads, so stale bytes cannot pass
    assign word = {m[3][mem_cmd.addr], m[2][mem_cmd.addr],
                   m[1][mem_cmd.addr], m[0][mem_cmd.addr]};
    assign mem_rdata = mem_cmd.rd ? word : ~word;

    // Byte writes per enabled map
    always @(posedge clk) begin
        for (int k = 0; k < 4; k++) begin
            if (mem_cmd.wr && mem_cmd.map_en[k]) begin
                m[k][mem_cmd.addr] <= mem_cmd.data[8*k +: 8];
            end
        end
    end
endmodule

// >>> testbench/vga_graphics_datapath_bench.sv
module vga_graphics_datapath_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata;
    vgd_pkg::vgd_ext_regs_t ext = '0;
    vgd_pkg::vgd_cpu_req_t cpu_req = '0;
    logic cpu_hit, cpu_rd_valid, gfx_sel, pix_six, pix_seven;
    logic [7:0] cpu_rdata;
    vgd_pkg::vgd_mem_cmd_t mem_cmd;
    logic [31:0] mem_rdata;
    logic vid_load = 1'b0;
    logic vid_dot_en = 1'b0;
    logic [31:0] vid_load_data = 32'h8000_0080;
    logic [95:0] palette_flat = '0;
    logic [3:0] attr_color_sel = 4'hC;
    logic [5:0] pix_low;
    logic ma0;
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [3:0] ri [5] = '{vgd_pkg::IDX_ROTATE, vgd_pkg::IDX_READ_MAP,
        vgd_pkg::IDX_MODE, vgd_pkg::IDX_MISC, 4'h7};
    logic [7:0] rm [5] = '{vgd_pkg::ROT_MASK, vgd_pkg::RMS_MASK,
        vgd_pkg::MODE_MASK, vgd_pkg::MISC_MASK, 8'h00};

    always #20 clk = ~clk;

    vgd_datapath u_vgd_datapath (.clk(clk), .rst_n(rst_n),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .ext(ext),
        .cpu_req(cpu_req), .cpu_hit(cpu_hit), .cpu_rdata(cpu_rdata),
        .cpu_rd_valid(cpu_rd_valid), .mem_cmd(mem_cmd),
        .mem_rdata(mem_rdata), .memory_addr_bit_zero(ma0),
        .vid_load(vid_load), .vid_dot_en(vid_dot_en),
        .vid_load_data(vid_load_data), .palette_flat(palette_flat),
        .attr_color_sel(attr_color_sel), .pixel_out_low_six(pix_low),
        .pixel_out_bit_six(pix_six), .pixel_out_bit_seven(pix_seven),
        .gfx_mode_sel(gfx_sel));

    vgd_mem_model u_vgd_mem_model (.clk(clk), .mem_cmd(mem_cmd),
        .mem_rdata(mem_rdata));

    task automatic give_verdict();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Hang guard, well above the roughly 180 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Strobe held one cycle, then one idle cycle before the next
    task automatic io_w(input logic [15:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic reg_w(input logic [3:0] i, input logic [7:0] d);
        io_w(vgd_pkg::IDX_PORT, {4'h0, i});
        io_w(vgd_pkg::DATA_PORT, d);
    endtask

    task automatic reg_chk(input logic [3:0] i, input logic [7:0] exp);
        io_w(vgd_pkg::IDX_PORT, {4'h0, i});
        io_addr = vgd_pkg::DATA_PORT;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        @(negedge clk);
        chk8(io_rdata, exp);
    endtask

    task automatic cpu_w(input logic [19:0] a, input logic [7:0] d);
        cpu_req.addr = a;
        cpu_req.data = d;
        cpu_req.wr = 1'b1;
        @(negedge clk);
        cpu_req.wr = 1'b0;
        @(negedge clk);
    endtask

    // Extra idle cycle after a read lets cpu_rd_valid drop again
    task automatic cpu_chk(input logic [19:0] a, input logic [7:0] exp);
        cpu_req.addr = a;
        cpu_req.rd = 1'b1;
        @(negedge clk);
        cpu_req.rd = 1'b0;
        for (int n = 0; n < 8 && cpu_rd_valid !== 1'b1; n++) @(negedge clk);
        chk8({7'h00, cpu_rd_valid}, 8'h01);
        chk8(cpu_rdata, exp);
        @(negedge clk);
    endtask

    task automatic mem_chk(input logic [15:0] a, input logic [31:0] exp);
        chk32({u_vgd_mem_model.m[3][a], u_vgd_mem_model.m[2][a],
               u_vgd_mem_model.m[1][a], u_vgd_mem_model.m[0][a]}, exp);
    endtask

    // One dot step, pixel seen two cycles later
    task automatic dot_chk(input logic [7:0] exp);
        vid_dot_en = 1'b1;
        @(negedge clk);
        vid_dot_en = 1'b0;
        repeat (2) @(negedge clk);
        chk8({pix_seven, pix_six, pix_low}, exp);
    endtask

    // Load pulse for the video shifters
    task automatic vid_ld();
        vid_load = 1'b1;
        @(negedge clk);
        vid_load = 1'b0;
    endtask

    // Main sequence
    initial begin
        for (int i = 0; i < 16; i++) palette_flat[6*i +: 6] = 6'(i) + 6'h10;
        ext.set_reset = 4'h1;
        ext.sr_enable = 4'h1;
        ext.bit_mask = 8'hFF;
        ext.map_mask = 4'hF;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        reg_chk(vgd_pkg::IDX_MODE, vgd_pkg::REG_RESET);
        for (int i = 0; i < 5; i++) begin
            reg_w(ri[i], 8'hFF);
            reg_chk(ri[i], rm[i]);
        end
        reg_w(vgd_pkg::IDX_MISC, 8'h05);
        chk8({7'h00, gfx_sel}, 8'h01);
        cpu_req.addr = 20'hB_0000;
        #1 chk8({7'h00, cpu_hit}, 8'h00);
        cpu_req.addr = 20'hA_FFFF;
        #1 chk8({7'h00, cpu_hit}, 8'h01);
        @(negedge clk);
        reg_w(vgd_pkg::IDX_ROTATE, 8'h01);
        reg_w(vgd_pkg::IDX_MODE, 8'h00);
        cpu_w(20'hA_0010, 8'h01);
        mem_chk(16'h0010, 32'h8080_80FF);
        reg_w(vgd_pkg::IDX_READ_MAP, 8'h02);
        cpu_chk(20'hA_0010, 8'h80);
        reg_w(vgd_pkg::IDX_ROTATE, 8'h18);
        ext.sr_enable = 4'h0;
        ext.bit_mask = 8'h0F;
        cpu_w(20'hA_0011, 8'h3C);
        mem_chk(16'h0011, 32'h8C8C_8CF3);
        reg_w(vgd_pkg::IDX_MODE, 8'h01);
        cpu_w(20'hA_0012, 8'h55);
        mem_chk(16'h0012, 32'h8080_80FF);
        reg_w(vgd_pkg::IDX_MODE, 8'h02);
        reg_w(vgd_pkg::IDX_ROTATE, 8'h00);
        ext.bit_mask = 8'hF0;
        cpu_w(20'hA_0013, 8'h05);
        mem_chk(16'h0013, 32'h00F0_00FF);
        reg_w(vgd_pkg::IDX_MODE, 8'h03);
        reg_w(vgd_pkg::IDX_ROTATE, 8'h01);
        ext.bit_mask = 8'hFF;
        ext.set_reset = 4'hA;
        cpu_w(20'hA_0014, 8'h06);
        mem_chk(16'h0014, 32'h8380_83FC);
        reg_w(vgd_pkg::IDX_MODE, 8'h08);
        ext.color_dc = 4'h1;
        cpu_chk(20'hA_0014, 8'h03);
        reg_w(vgd_pkg::IDX_MISC, 8'h07);
        reg_w(vgd_pkg::IDX_MODE, 8'h00);
        reg_w(vgd_pkg::IDX_ROTATE, 8'h00);
        cpu_w(20'hA_0020, 8'h5A);
        mem_chk(16'h0020, 32'h005A_005A);
        ext.seq_chain4 = 1'b1;
        cpu_chk(20'hA_0010, 8'hFF);
        ext.seq_chain4 = 1'b0;
        reg_w(vgd_pkg::IDX_MISC, 8'h03);
        reg_w(vgd_pkg::IDX_ROTATE, 8'h10);
        cpu_w(20'hB_0020, 8'h5A);
        chk8({7'h00, ma0}, 8'h01);
        mem_chk(16'h0021, 32'h00DA_00FF);
        vid_ld();
        dot_chk(8'hD9);
        dot_chk(8'hD0);
        reg_w(vgd_pkg::IDX_MODE, 8'h20);
        vid_ld();
        dot_chk(8'hD2);
        reg_w(vgd_pkg::IDX_MODE, 8'h40);
        vid_ld();
        dot_chk(8'h82);
        give_verdict();
    end
endmodule
